// file: core/bst_tap.sv
// Boundary scan test port of a synchronous memory: controller, instruction,
// bypass, identification and boundary registers, and pin control hand-off.
// Assumes the scan clock tck is unrelated to ref_clk and may stop between scans.
//
// Function
// - Provide 3-bit instruction, 1-bit bypass, 32-bit identification, 109-cell boundary registers.
// - Code 000 captures the input and output ring into the boundary register.
// - Code 001 loads and shifts the identification word, memory unaffected.
// - Code 010 captures pins, shifts boundary register, floats all memory outputs.
// - Code 100 captures the ring, shifts boundary register, memory unaffected.
// - Code 111 puts the one-bit bypass cell between data in and out.
// - Identification holds revision 31:29, part 28:12, vendor 11:1.
// - Identification bit 0 always reads one.
// - During code 000 preloaded cell values drive the system outputs.
// - During code 000 cell 108 high enables data drivers, low floats them.
// - Cell 108 presets high at power-up and in the reset state.
`timescale 1ns/100ps
module bst_tap #(
	parameter int BSR_LEN = bst_pkg::BSR_LEN
) (
	// System clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Scan link from the board test controller.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Ring of sampled pin levels, and the memory core's own output enable.
	input wire logic [BSR_LEN-2:0] pin_sample,
	input wire logic core_q_oe,
	// Pin control towards the pad ring.
	output logic [BSR_LEN-2:0] pin_drive,
	output logic pin_extest,
	output logic q_oe
);
	// -----------------------------------------------------------------
	// Elaboration check
	// -----------------------------------------------------------------
	if (BSR_LEN != bst_pkg::OE_CELL + 1) begin : g_bad_len
		$error("boundary length must place the output control cell last");
	end

	// -----------------------------------------------------------------
	// Decode helpers
	// -----------------------------------------------------------------
	// Instructions that put the boundary register on the scan path.
	function automatic logic is_bsr(input logic [2:0] ins);
		is_bsr = (ins == bst_pkg::INS_EXTEST) || (ins == bst_pkg::INS_SAMPLE_Z) ||
			(ins == bst_pkg::INS_SAMPLE);
	endfunction

	// Standard controller transitions on the sampled mode bit.
	function automatic bst_pkg::bst_state_t step(input bst_pkg::bst_state_t s, input logic m);
		case (s)
			bst_pkg::ST_RESET: step = m ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
			bst_pkg::ST_IDLE: step = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_DR: step = m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR: step = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_SH_DR: step = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_EX1_DR: step = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
			bst_pkg::ST_PAU_DR: step = m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
			bst_pkg::ST_EX2_DR: step = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_UPD_DR: step = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_IR: step = m ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR: step = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_SH_IR: step = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_EX1_IR: step = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
			bst_pkg::ST_PAU_IR: step = m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
			bst_pkg::ST_EX2_IR: step = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_UPD_IR: step = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			default: step = bst_pkg::ST_RESET;
		endcase
	endfunction

	// -----------------------------------------------------------------
	// Scan clock domain: synchronisers
	// -----------------------------------------------------------------
	logic rst_meta_reg, rst_tck_reg;
	logic [BSR_LEN-2:0] pin_meta_reg, pin_sync_reg;
	logic ack_meta_reg, ack_sync_reg;
	logic ack_reg, ack_next;

	// Reset, pin levels and the return acknowledge each pass two flops before use.
	always_ff @(posedge tck) begin
		rst_meta_reg <= sys_rst;
		rst_tck_reg <= rst_meta_reg;
		pin_meta_reg <= pin_sample;
		pin_sync_reg <= pin_meta_reg;
		ack_meta_reg <= ack_reg;
		ack_sync_reg <= ack_meta_reg;
	end

	// -----------------------------------------------------------------
	// Scan clock domain: controller and scan registers
	// -----------------------------------------------------------------
	bst_pkg::bst_state_t state_reg, state_next;
	logic [2:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
	logic byp_reg, byp_next;
	logic [bst_pkg::ID_LEN-1:0] id_sh_reg, id_sh_next;
	logic [BSR_LEN-1:0] bsr_sh_reg, bsr_sh_next, bsr_upd_reg, bsr_upd_next;
	bst_pkg::bst_xfer_t xfer_reg, xfer_next, xfer_live;
	logic req_reg, req_next;
	bst_pkg::bst_id_word_t id_word;

	assign id_word = '{revision: bst_pkg::ID_REVISION, part: bst_pkg::ID_PART,
		vendor: bst_pkg::ID_VENDOR, present: bst_pkg::ID_PRESENT};

	// Next values of the controller, the shift paths and the update latches.
	always_comb begin
		state_next = step(state_reg, tms);
		ir_sh_next = ir_sh_reg;
		ir_next = ir_reg;
		byp_next = byp_reg;
		id_sh_next = id_sh_reg;
		bsr_sh_next = bsr_sh_reg;
		bsr_upd_next = bsr_upd_reg;
		case (state_reg)
			bst_pkg::ST_RESET: begin
				ir_next = bst_pkg::INS_IDCODE;
				bsr_upd_next[bst_pkg::OE_CELL] = bst_pkg::OE_CELL_PRESET;
			end
			bst_pkg::ST_CAP_IR: ir_sh_next = bst_pkg::IR_CAPTURE;
			bst_pkg::ST_SH_IR: ir_sh_next = {tdi, ir_sh_reg[2:1]};
			bst_pkg::ST_UPD_IR: ir_next = ir_sh_reg;
			bst_pkg::ST_CAP_DR: begin
				byp_next = bst_pkg::BYPASS_CAPTURE;
				id_sh_next = id_word;
				// The internal cell has no ball, so it samples its own latch.
				if (is_bsr(ir_reg)) begin
					bsr_sh_next = {bsr_upd_reg[bst_pkg::OE_CELL], pin_sync_reg};
				end
			end
			bst_pkg::ST_SH_DR: begin
				byp_next = tdi;
				id_sh_next = {tdi, id_sh_reg[bst_pkg::ID_LEN-1:1]};
				bsr_sh_next = {tdi, bsr_sh_reg[BSR_LEN-1:1]};
			end
			bst_pkg::ST_UPD_DR: begin
				if (is_bsr(ir_reg)) begin
					bsr_upd_next = bsr_sh_reg;
				end
			end
			default: begin
			end
		endcase
		// System reset also clears the update latches except cell 108, which presets high, so the first hand-off compares known values.
		if (rst_tck_reg) begin
			state_next = bst_pkg::ST_RESET;
			bsr_upd_next = '0;
			bsr_upd_next[bst_pkg::OE_CELL] = bst_pkg::OE_CELL_PRESET;
		end
	end

	// Live pin-control word, built from the next values so that an update is offered on its own
	// edge even when the scan clock stops right after it; offered only when the last one was taken.
	always_comb begin
		xfer_live.extest = (ir_next == bst_pkg::INS_EXTEST);
		xfer_live.hiz = (ir_next == bst_pkg::INS_SAMPLE_Z);
		xfer_live.cells = bsr_upd_next;
		xfer_next = xfer_reg;
		req_next = req_reg;
		if ((req_reg == ack_sync_reg) && (xfer_live != xfer_reg)) begin
			xfer_next = xfer_live;
			req_next = ~req_reg;
		end
		// The reset word matches the one the system side resets to.
		if (rst_tck_reg) begin
			xfer_next = '{extest: 1'b0, hiz: 1'b0, cells: '0};
			xfer_next.cells[bst_pkg::OE_CELL] = bst_pkg::OE_CELL_PRESET;
			req_next = 1'b0;
		end
	end

	// Register the scan clock group.
	always_ff @(posedge tck) begin
		state_reg <= state_next;
		ir_sh_reg <= ir_sh_next;
		ir_reg <= ir_next;
		byp_reg <= byp_next;
		id_sh_reg <= id_sh_next;
		bsr_sh_reg <= bsr_sh_next;
		bsr_upd_reg <= bsr_upd_next;
		xfer_reg <= xfer_next;
		req_reg <= req_next;
	end

	// -----------------------------------------------------------------
	// Scan clock domain: serial output on the falling edge
	// -----------------------------------------------------------------
	logic tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;

	// Select the stage on the path; reserved codes fall back to the bypass cell.
	always_comb begin
		tdo_next = tdo_reg;
		tdo_oe_next = 1'b0;
		if (state_reg == bst_pkg::ST_SH_IR) begin
			tdo_next = ir_sh_reg[0];
			tdo_oe_next = 1'b1;
		end else if (state_reg == bst_pkg::ST_SH_DR) begin
			tdo_oe_next = 1'b1;
			if (is_bsr(ir_reg)) begin
				tdo_next = bsr_sh_reg[0];
			end else if (ir_reg == bst_pkg::INS_IDCODE) begin
				tdo_next = id_sh_reg[0];
			end else begin
				tdo_next = byp_reg;
			end
		end
		// A known idle level keeps the far end from seeing an unknown before the first shift.
		if (rst_tck_reg) begin
			tdo_next = 1'b0;
			tdo_oe_next = 1'b0;
		end
	end

	// Changing on the falling edge gives the far end a half period of setup.
	always_ff @(negedge tck) begin
		tdo_reg <= tdo_next;
		tdo_oe_reg <= tdo_oe_next;
	end

	assign tdo = tdo_reg;
	assign tdo_oe = tdo_oe_reg;

	// -----------------------------------------------------------------
	// System clock domain: take the word and drive the pads
	// -----------------------------------------------------------------
	logic req_meta_reg, req_sync_reg;
	bst_pkg::bst_xfer_t held_reg, held_next;
	logic [BSR_LEN-2:0] drive_reg, drive_next;
	logic extest_reg, extest_next, q_oe_reg, q_oe_next;

	// The word is stable while the request toggle differs from the acknowledge.
	always_comb begin
		ack_next = ack_reg;
		held_next = held_reg;
		if (req_sync_reg != ack_reg) begin
			ack_next = req_sync_reg;
			held_next = xfer_reg;
		end
		drive_next = held_reg.cells[BSR_LEN-2:0];
		extest_next = held_reg.extest;
		if (held_reg.extest) begin
			q_oe_next = held_reg.cells[bst_pkg::OE_CELL];
		end else if (held_reg.hiz) begin
			q_oe_next = 1'b0;
		end else begin
			q_oe_next = core_q_oe;
		end
		if (sys_rst) begin
			ack_next = 1'b0;
			held_next = '{extest: 1'b0, hiz: 1'b0, cells: '0};
			held_next.cells[bst_pkg::OE_CELL] = bst_pkg::OE_CELL_PRESET;
			drive_next = '0;
			extest_next = 1'b0;
			q_oe_next = 1'b0;
		end
	end

	// Register the system clock group; the request toggle is synchronised first.
	always_ff @(posedge ref_clk) begin
		req_meta_reg <= req_reg;
		req_sync_reg <= req_meta_reg;
		ack_reg <= ack_next;
		held_reg <= held_next;
		drive_reg <= drive_next;
		extest_reg <= extest_next;
		q_oe_reg <= q_oe_next;
	end

	assign pin_drive = drive_reg;
	assign pin_extest = extest_reg;
	assign q_oe = q_oe_reg;
endmodule // bst_tap

// file: core/bst_pkg.sv
// Constants, state codes and carrier types of the boundary scan test port.
// Assumes a consumer that names every item as bst_pkg::name.
package bst_pkg;
	// -----------------------------------------------------------------
	// Scan path sizes
	// -----------------------------------------------------------------
	localparam int IR_LEN = 3;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN = 109;
	localparam int OE_CELL = 108;
	// -----------------------------------------------------------------
	// Instruction codes and capture pattern
	// -----------------------------------------------------------------
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_IDCODE = 3'h1;
	localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0] INS_SAMPLE = 3'h4;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	// -----------------------------------------------------------------
	// Identification word fields, bypass capture and cell 108 preset; revision, part and vendor values are arbitrary.
	// -----------------------------------------------------------------
	localparam logic [2:0] ID_REVISION = 3'h5;
	localparam logic [16:0] ID_PART = 17'h0_1234;
	localparam logic [10:0] ID_VENDOR = 11'h155;
	localparam logic ID_PRESENT = 1'b1;
	localparam logic BYPASS_CAPTURE = 1'b0;
	localparam logic OE_CELL_PRESET = 1'b1;
	// Bit 31:29 revision, 28:12 part type, 11:1 vendor, 0 presence.
	typedef struct packed {
		logic [2:0] revision;
		logic [16:0] part;
		logic [10:0] vendor;
		logic present;
	} bst_id_word_t;
	// Word handed from the scan clock domain to the system clock domain.
	typedef struct packed {
		logic extest;
		logic hiz;
		logic [BSR_LEN-1:0] cells;
	} bst_xfer_t;
	// -----------------------------------------------------------------
	// Test controller states
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
		ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
	} bst_state_t;
endpackage

// file: test/bst_tap_sva.sv
// Checker of the scan link and pin control of the boundary scan test port.
// Assumes it is bound to bst_tap and sees nothing but its ports.
`timescale 1ns/100ps
module bst_tap_sva #(
	parameter int BSR_LEN = bst_pkg::BSR_LEN
) (
	// Watched ports, inputs and outputs alike.
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [BSR_LEN-2:0] pin_sample,
	input wire logic core_q_oe,
	input wire logic [BSR_LEN-2:0] pin_drive,
	input wire logic pin_extest,
	input wire logic q_oe
);
	// ----------------------------------------------------------------
	// Scan link
	// ----------------------------------------------------------------
	// Five high mode bits reach the reset state from anywhere, so the output must be off.
	property p_tlr_quiet; @(posedge tck) disable iff (sys_rst) tms [*5] |-> !tdo_oe; endproperty
	a_tlr_quiet: assert property (p_tlr_quiet) else $error("Scan out on in reset state.");
	property p_id_first; @(posedge tck) disable iff (sys_rst)
		tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo_oe && tdo; endproperty
	a_id_first: assert property (p_id_first) else $error("First word bit not one.");
	property p_ir_capture; @(posedge tck) disable iff (sys_rst)
		!tms ##1 tms [*2] ##1 !tms [*3] |-> tdo && tdo_oe ##1 !tdo; endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("Instruction capture wrong.");
	property p_shift_exit; @(posedge tck) disable iff (sys_rst) tdo_oe && tms |=> !tdo_oe; endproperty
	a_shift_exit: assert property (p_shift_exit) else $error("Scan out stays on after shift.");
	property p_tdo_hold; @(posedge tck) disable iff (sys_rst) !tdo_oe && $past(!tdo_oe) |-> $stable(tdo); endproperty
	a_tdo_hold: assert property (p_tdo_hold) else $error("Scan out moved while idle.");
	property p_oe_start; @(posedge tck) disable iff (sys_rst) $rose(tdo_oe) |-> !$past(tms); endproperty
	a_oe_start: assert property (p_oe_start) else $error("Shift entered on high mode bit.");
	// ----------------------------------------------------------------
	// Pin control
	// ----------------------------------------------------------------
	// Reset must float the outputs, so this one is not disabled by reset.
	property p_rst_pins; @(posedge ref_clk) sys_rst |=> pin_drive == '0 && !pin_extest && !q_oe; endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("Pins not safe in reset.");
	property p_q_oe_core; @(posedge ref_clk) disable iff (sys_rst) q_oe && !pin_extest |-> $past(core_q_oe); endproperty
	a_q_oe_core: assert property (p_q_oe_core) else $error("Output enable without core request.");
endmodule // bst_tap_sva
bind bst_tap bst_tap_sva #(.BSR_LEN(BSR_LEN)) bst_tap_sva_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck),
	.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_sample(pin_sample), .core_q_oe(core_q_oe),
	.pin_drive(pin_drive), .pin_extest(pin_extest), .q_oe(q_oe));

// file: test/bst_jtag_host.sv
// Model of the board test controller that drives the scan link.
// Assumes the device samples on the rising edge and answers on the falling edge.
`timescale 1ns/100ps
module bst_jtag_host (
	// Scan link.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// The scan clock stands low between frames.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One full 30 ns scan clock period; the answer is taken at the rising edge.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#15 tck = 1'b1;
		q = tdo;
		#15 tck = 1'b0;
	endtask
	// Five high mode bits reach the reset state, then one low bit goes to idle.
	task automatic to_idle();
		logic q;
		repeat (5) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
	// Scan from idle to idle; outside shift the data line toggles so stale data cannot pass.
	task automatic scan(input logic ir, input logic [108:0] din, input int n, output logic [108:0] dout);
		logic q;
		dout = '0;
		#7;
		step(1'b1, ~tdi, q);
		if (ir) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
endmodule // bst_jtag_host

// file: test/bst_tap_tb_top.sv
// Self-checking bench of the boundary scan test port.
// Assumes the checker is bound in and the host model drives the scan link.
`timescale 1ns/100ps
module bst_tap_tb_top;
	logic ref_clk, sys_rst, tck, tms, tdi, tdo, q, core_q_oe, pin_extest, q_oe;
	logic [107:0] pin_sample, pin_drive;
	logic [108:0] dout;
	int failures, samples_checked;
	bst_tap #(.BSR_LEN(bst_pkg::BSR_LEN)) bst_tap_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(), .pin_sample(pin_sample), .core_q_oe(core_q_oe),
		.pin_drive(pin_drive), .pin_extest(pin_extest), .q_oe(q_oe));
	bst_jtag_host bst_jtag_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// System clock of 40 ns.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic ok, input string what);
		samples_checked++;
		if (!ok) begin
			failures++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	// Pin control crosses clocks, so its arrival is awaited under a bound.
	task automatic wait_pin(input logic sel_q, input logic want, input string what);
		int i;
		#1;
		for (i = 0; i < 40 && (sel_q ? q_oe : pin_extest) !== want; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk((sel_q ? q_oe : pin_extest) === want, what);
		if (i == 40) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic t_idcode();
		bst_jtag_host_inst.scan(1'b0, 109'h0, 32, dout);
		chk(dout[31:0] === {bst_pkg::ID_REVISION, bst_pkg::ID_PART, bst_pkg::ID_VENDOR, 1'b1}, "id word");
		bst_jtag_host_inst.scan(1'b1, 109'(bst_pkg::INS_IDCODE), 3, dout);
		chk(dout[2:0] === bst_pkg::IR_CAPTURE && q_oe === core_q_oe, "ir capture");
	endtask
	task automatic t_bypass();
		bst_jtag_host_inst.scan(1'b1, 109'(bst_pkg::INS_BYPASS), 3, dout);
		bst_jtag_host_inst.scan(1'b0, 109'h5a, 8, dout);
		chk(dout[7:0] === 8'hb4, "bypass path");
		@(posedge ref_clk);
		core_q_oe <= 1'b0;
		wait_pin(1'b1, 1'b0, "core enable off");
		@(posedge ref_clk);
		core_q_oe <= 1'b1;
		wait_pin(1'b1, 1'b1, "core enable on");
	endtask
	// Cell 108 is captured from its own latch, so each capture shows the last update.
	task automatic t_ring();
		bst_jtag_host_inst.scan(1'b1, 109'(bst_pkg::INS_SAMPLE_Z), 3, dout);
		wait_pin(1'b1, 1'b0, "outputs float");
		bst_jtag_host_inst.scan(1'b0, 109'h0, 109, dout);
		chk(dout === {1'b1, pin_sample}, "float capture");
		bst_jtag_host_inst.scan(1'b1, 109'(bst_pkg::INS_SAMPLE), 3, dout);
		wait_pin(1'b1, 1'b1, "sample leaves core");
		bst_jtag_host_inst.scan(1'b0, {1'b0, ~pin_sample}, 109, dout);
		chk(dout === {1'b0, pin_sample} && pin_extest === 1'b0, "sample capture");
		bst_jtag_host_inst.scan(1'b1, 109'(bst_pkg::INS_EXTEST), 3, dout);
		wait_pin(1'b0, 1'b1, "extest entered");
		chk(pin_drive === ~pin_sample && q_oe === 1'b0, "preload driven, bus floats");
		bst_jtag_host_inst.scan(1'b0, {1'b1, pin_sample}, 109, dout);
		chk(dout === {1'b0, pin_sample}, "extest capture");
		wait_pin(1'b1, 1'b1, "cell enables bus");
		chk(pin_drive === pin_sample, "new drive");
	endtask
	task automatic t_tlr();
		bst_jtag_host_inst.to_idle();
		wait_pin(1'b0, 1'b0, "reset state ends extest");
		bst_jtag_host_inst.scan(1'b1, 109'(bst_pkg::INS_SAMPLE), 3, dout);
		bst_jtag_host_inst.scan(1'b0, 109'h0, 109, dout);
		chk(dout[108] === 1'b1, "cell preset");
	endtask
	task automatic report_and_stop();
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Reset runs the scan clock too, so the scan side is reset as well.
	initial begin
		sys_rst = 1'b1;
		core_q_oe = 1'b1;
		// A pattern that differs from its own mirror image, so a reversed ring would show.
		pin_sample = {27{4'h3}};
		failures = 0;
		samples_checked = 0;
		fork
			repeat (3) @(posedge ref_clk);
			repeat (3) bst_jtag_host_inst.step(1'b1, 1'b0, q);
		join
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		bst_jtag_host_inst.to_idle();
		t_idcode();
		t_bypass();
		t_ring();
		t_tlr();
		report_and_stop();
	end
endmodule // bst_tap_tb_top
